// ### rtl/trc_pkg.sv
package trc_pkg;
  // Register offsets on the parallel port
  localparam logic [7:0] RX_CTRL_TWO_ADDR = 8'h2C;
  localparam logic [7:0] TX_CTRL_ONE_ADDR = 8'h35;
  localparam logic [7:0] COMMON_CTRL_ONE_ADDR = 8'h37;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Receive control two fields
  localparam int RX_CODE_SELECT_BIT = 7;
  localparam int RX_ZBTSI_ENABLE_BIT = 6;
  localparam int RX_SYNC_DOUBLE_WIDE_BIT = 5;
  localparam int RX_SYNC_MF_SELECT_BIT = 4;
  localparam int RX_SYNC_DIRECTION_BIT = 3;
  localparam int RX_YELLOW_STYLE_BIT = 2;
  localparam int FS_ERROR_REPORT_BIT = 1;
  localparam int MF_OOS_COUNT_BIT = 0;

  // Transmit control one fields
  localparam int TX_CLK_FAILOVER_BIT = 7;
  localparam int TX_FBIT_PASS_BIT = 6;
  localparam int TX_CRC_PASS_BIT = 5;
  localparam int SW_SIG_INSERT_BIT = 4;
  localparam int GLOBAL_BIT7_STUFF_BIT = 3;
  localparam int TX_DATALINK_SRC_BIT = 2;
  localparam int TX_BLUE_ALARM_BIT = 1;
  localparam int TX_YELLOW_ALARM_BIT = 0;

  // Common control one field
  localparam int RX_ELASTIC_ENABLE_BIT = 2;

  // Replacement codes
  localparam logic [7:0] IDLE_CODE = 8'h7F;
  localparam int MILLIWATT_LEN = 8;
  localparam logic [63:0] MILLIWATT_SEQ = 64'h1E0B0B1E9E8B8B9E;

  // Transmit clock loss detection
  localparam int CLK_PERIOD_NS = 10;
  localparam int TX_CLK_LOSS_NS = 1000;
  localparam int TX_CLK_LOSS_CYCLES = TX_CLK_LOSS_NS / CLK_PERIOD_NS;

  localparam int CHANNELS = 24;
  localparam int ERR_COUNT_WIDTH = 16;
endpackage

// ### rtl/trc_event_counter.sv
`timescale 1ns/100ps
`default_nettype none
module trc_event_counter import trc_pkg::*; #(
  parameter int WIDTH = ERR_COUNT_WIDTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic inc,
  input wire logic clr,
  // Result
  output logic [WIDTH-1:0] count
);
  initial begin
    if (WIDTH < 2) begin
      $error("trc_event_counter: WIDTH too small");
    end
  end

  // Saturates so a long unattended run never wraps to a small figure
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clr) begin
      count <= {{(WIDTH-1){1'b0}}, inc};
    end else if (inc && count != {WIDTH{1'b1}}) begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### rtl/trc_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
module trc_control_regs import trc_pkg::*; #(
  parameter int NUM_CHANNELS = CHANNELS,
  parameter int COUNT_WIDTH = ERR_COUNT_WIDTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Parallel host port
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [7:0] busRdData,
  output logic busRdValid,
  // Receive framer events
  input wire logic rxByteStrobe,
  input wire logic rxFrameStart,
  input wire logic rxMultiframeStart,
  input wire logic rxSignalingFrame,
  input wire logic rxBit2AllZero,
  input wire logic rxFrame12SBit,
  input wire logic ftBitError,
  input wire logic fsBitError,
  input wire logic mfOutOfSync,
  input wire logic errCountClear,
  // Receive outputs
  output logic [7:0] replaceCode,
  output logic rxZbtsiEnable,
  output logic rxSyncOut,
  output logic rxSyncOe,
  output logic rxYellowDetected,
  output logic [COUNT_WIDTH-1:0] errCount,
  output logic rxElasticEnable,
  // Transmit side
  input wire logic txClkToggle,
  input wire logic txSerialBit,
  input wire logic txHdlcBit,
  input wire logic txLegacyBit,
  input wire logic txPosIn,
  input wire logic txNegIn,
  input wire logic [NUM_CHANNELS-1:0] txTransparency,
  output logic txClkUseRx,
  output logic txFbitFromSerial,
  output logic txCrcFromSerial,
  output logic [NUM_CHANNELS-1:0] sigInsert,
  output logic [NUM_CHANNELS-1:0] bit7Stuff,
  output logic txDatalinkBit,
  output logic txLineOutPos,
  output logic txLineOutNeg,
  output logic txYellowAlarm
);
  localparam int LOSS_W = $clog2(TX_CLK_LOSS_CYCLES + 1);
  localparam logic [LOSS_W-1:0] LOSS_LIMIT =
    LOSS_W'(TX_CLK_LOSS_CYCLES);

  initial begin
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > 32) begin
      $error("trc_control_regs: NUM_CHANNELS out of range");
    end
  end

  logic [7:0] rxCtrl;
  logic [7:0] txCtrl;
  logic [7:0] commonCtrl;
  logic [2:0] codeIndex;
  logic syncHold;
  logic [LOSS_W-1:0] lossCount;
  logic prevTxClk;
  logic countInc;
  logic [7:0] next_rdData;

  // Registers cleared by reset; software still zeroes the map first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCtrl <= REG_RESET;
      txCtrl <= REG_RESET;
      commonCtrl <= REG_RESET;
    end else if (busWrite) begin
      case (busAddr)
        RX_CTRL_TWO_ADDR: rxCtrl <= busWrData;
        TX_CTRL_ONE_ADDR: txCtrl <= busWrData;
        COMMON_CTRL_ONE_ADDR: commonCtrl <= busWrData;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (busAddr)
      RX_CTRL_TWO_ADDR: next_rdData = rxCtrl;
      TX_CTRL_ONE_ADDR: next_rdData = txCtrl;
      COMMON_CTRL_ONE_ADDR: next_rdData = commonCtrl;
      default: next_rdData = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busRdData <= 8'h00;
      busRdValid <= 1'b0;
    end else begin
      busRdValid <= busRead;
      if (busRead) begin
        busRdData <= next_rdData;
      end
    end
  end

  // Replacement code; milliwatt pattern steps once per channel byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      codeIndex <= 3'h0;
      replaceCode <= IDLE_CODE;
    end else begin
      if (!rxCtrl[RX_CODE_SELECT_BIT]) begin
        codeIndex <= 3'h0;
        replaceCode <= IDLE_CODE;
      end else if (rxByteStrobe) begin
        codeIndex <= codeIndex + 3'h1;
        replaceCode <= MILLIWATT_SEQ[63 - 8*codeIndex -: 8];
      end
    end
  end

  // Receive sync pin: direction, rate and double width
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSyncOe <= 1'b1;
      rxSyncOut <= 1'b0;
      syncHold <= 1'b0;
    end else begin
      rxSyncOe <= !rxCtrl[RX_SYNC_DIRECTION_BIT];
      if (rxCtrl[RX_SYNC_DIRECTION_BIT]) begin
        // Rate select has no effect while the pin is an input
        rxSyncOut <= 1'b0;
        syncHold <= 1'b0;
      end else if (rxCtrl[RX_SYNC_MF_SELECT_BIT] ? rxMultiframeStart
                                                 : rxFrameStart) begin
        rxSyncOut <= 1'b1;
        // Double width is gated off in multiframe mode; input mode never reaches here
        syncHold <= rxCtrl[RX_SYNC_DOUBLE_WIDE_BIT] && rxSignalingFrame &&
                    !rxCtrl[RX_SYNC_MF_SELECT_BIT];
      end else begin
        rxSyncOut <= syncHold;
        syncHold <= 1'b0;
      end
    end
  end

  // Receive status and control decode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxZbtsiEnable <= 1'b0;
      rxYellowDetected <= 1'b0;
      rxElasticEnable <= 1'b0;
    end else begin
      rxZbtsiEnable <= rxCtrl[RX_ZBTSI_ENABLE_BIT];
      rxYellowDetected <= rxCtrl[RX_YELLOW_STYLE_BIT] ?
                          rxFrame12SBit : rxBit2AllZero;
      rxElasticEnable <= commonCtrl[RX_ELASTIC_ENABLE_BIT];
    end
  end

  // Error counter source selection
  always_comb begin
    if (rxCtrl[MF_OOS_COUNT_BIT]) begin
      countInc = mfOutOfSync;
    end else begin
      countInc = ftBitError ||
                 (rxCtrl[FS_ERROR_REPORT_BIT] && fsBitError);
    end
  end

  trc_event_counter #(
    .WIDTH(COUNT_WIDTH)
  ) u_err_counter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inc(countInc),
    .clr(errCountClear),
    .count(errCount)
  );

  // Transmit clock watchdog; a stopped clock is one with no toggle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevTxClk <= 1'b0;
      lossCount <= '0;
      txClkUseRx <= 1'b0;
    end else begin
      prevTxClk <= txClkToggle;
      if (txClkToggle != prevTxClk) begin
        lossCount <= '0;
      end else if (lossCount != LOSS_LIMIT) begin
        lossCount <= lossCount + 1'b1;
      end
      txClkUseRx <= txCtrl[TX_CLK_FAILOVER_BIT] &&
                    lossCount == LOSS_LIMIT;
    end
  end

  // Transmit formatter selects
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txFbitFromSerial <= 1'b0;
      txCrcFromSerial <= 1'b0;
      txDatalinkBit <= 1'b0;
      txLineOutPos <= 1'b0;
      txLineOutNeg <= 1'b0;
      txYellowAlarm <= 1'b0;
    end else begin
      txFbitFromSerial <= txCtrl[TX_FBIT_PASS_BIT];
      txCrcFromSerial <= txCtrl[TX_CRC_PASS_BIT];
      txDatalinkBit <= txCtrl[TX_DATALINK_SRC_BIT] ? txHdlcBit
                                                   : txLegacyBit;
      // Blue alarm overrides framing and payload on both rails
      txLineOutPos <= txCtrl[TX_BLUE_ALARM_BIT] | txPosIn;
      txLineOutNeg <= txCtrl[TX_BLUE_ALARM_BIT] | txNegIn;
      txYellowAlarm <= txCtrl[TX_YELLOW_ALARM_BIT];
    end
  end

  // Per-channel signaling insertion and bit-7 stuffing
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sigInsert[ch] <= 1'b0;
          bit7Stuff[ch] <= 1'b0;
        end else begin
          sigInsert[ch] <= txCtrl[SW_SIG_INSERT_BIT] &&
                           !txTransparency[ch];
          bit7Stuff[ch] <= txCtrl[GLOBAL_BIT7_STUFF_BIT] ||
                           txTransparency[ch];
        end
      end
    end
  endgenerate

  // Checks
  property p_idle_code;
    @(posedge ref_clk) disable iff (!rst_n)
      !rxCtrl[RX_CODE_SELECT_BIT] |=> replaceCode == IDLE_CODE;
  endproperty
  a_idle_code: assert property (p_idle_code)
    else $error("idle code not selected");

  property p_zbtsi;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 rxZbtsiEnable == $past(rxCtrl[RX_ZBTSI_ENABLE_BIT]);
  endproperty
  a_zbtsi: assert property (p_zbtsi)
    else $error("zbtsi enable mismatch");

  property p_double_wide;
    @(posedge ref_clk) disable iff (!rst_n)
      (rxCtrl == 8'h20 && rxFrameStart && rxSignalingFrame) ##1
      (rxCtrl == 8'h20 && !rxFrameStart) |-> rxSyncOut ##1 rxSyncOut;
  endproperty
  a_double_wide: assert property (p_double_wide)
    else $error("sync pulse not double wide");

  property p_sync_mf;
    @(posedge ref_clk) disable iff (!rst_n)
      (rxCtrl[RX_SYNC_MF_SELECT_BIT] && !rxCtrl[RX_SYNC_DIRECTION_BIT] &&
       rxMultiframeStart) |=> rxSyncOut;
  endproperty
  a_sync_mf: assert property (p_sync_mf)
    else $error("multiframe sync pulse missing");

  property p_sync_input;
    @(posedge ref_clk) disable iff (!rst_n)
      rxCtrl[RX_SYNC_DIRECTION_BIT] |=> !rxSyncOe && !rxSyncOut;
  endproperty
  a_sync_input: assert property (p_sync_input)
    else $error("sync pin driven while input");

  property p_yellow;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 rxYellowDetected == ($past(rxCtrl[RX_YELLOW_STYLE_BIT]) ?
        $past(rxFrame12SBit) : $past(rxBit2AllZero));
  endproperty
  a_yellow: assert property (p_yellow)
    else $error("yellow detect style wrong");

  property p_fs_ignored;
    @(posedge ref_clk) disable iff (!rst_n)
      (rxCtrl[1:0] == 2'b00 && fsBitError && !ftBitError &&
       !errCountClear) |=> $stable(errCount);
  endproperty
  a_fs_ignored: assert property (p_fs_ignored)
    else $error("Fs error counted while disabled");

  property p_oos_count;
    @(posedge ref_clk) disable iff (!rst_n)
      (rxCtrl[MF_OOS_COUNT_BIT] && mfOutOfSync && !errCountClear &&
       errCount < 16'h00FF) |=> errCount == $past(errCount) + 1'b1;
  endproperty
  a_oos_count: assert property (p_oos_count)
    else $error("out-of-sync multiframe not counted");

  property p_no_failover;
    @(posedge ref_clk) disable iff (!rst_n)
      !txCtrl[TX_CLK_FAILOVER_BIT] |=> !txClkUseRx;
  endproperty
  a_no_failover: assert property (p_no_failover)
    else $error("failover while disabled");

  property p_blue;
    @(posedge ref_clk) disable iff (!rst_n)
      txCtrl[TX_BLUE_ALARM_BIT] |=> txLineOutPos && txLineOutNeg;
  endproperty
  a_blue: assert property (p_blue)
    else $error("blue alarm not all ones");

  property p_stuff;
    @(posedge ref_clk) disable iff (!rst_n)
      txCtrl[GLOBAL_BIT7_STUFF_BIT] |=> &bit7Stuff;
  endproperty
  a_stuff: assert property (p_stuff)
    else $error("global stuffing incomplete");

  property p_elastic;
    @(posedge ref_clk) disable iff (!rst_n)
      ##1 rxElasticEnable == $past(commonCtrl[RX_ELASTIC_ENABLE_BIT]);
  endproperty
  a_elastic: assert property (p_elastic)
    else $error("elastic enable mismatch");

  c_milliwatt: cover property (@(posedge ref_clk) disable iff (!rst_n)
    rxCtrl[RX_CODE_SELECT_BIT] && rxByteStrobe);
  c_failover: cover property (@(posedge ref_clk) disable iff (!rst_n)
    txClkUseRx);
  c_sync_input: cover property (@(posedge ref_clk) disable iff (!rst_n)
    !rxSyncOe);
endmodule
`default_nettype wire

// ### test/trc_control_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module trc_control_regs_tb_top import trc_pkg::*;;
  logic ref_clk = 0, rst_n = 0;
  logic [7:0] busAddr = 0, busWrData = 0, busRdData;
  logic busWrite = 0, busRead = 0, busRdValid;
  logic rxByteStrobe = 0, rxFrameStart = 0, rxMultiframeStart = 0;
  logic rxSignalingFrame = 0, rxBit2AllZero = 0, rxFrame12SBit = 0;
  logic ftBitError = 0, fsBitError = 0, mfOutOfSync = 0;
  logic errCountClear = 0;
  logic [7:0] replaceCode;
  logic rxZbtsiEnable, rxSyncOut, rxSyncOe, rxYellowDetected;
  logic [15:0] errCnt;
  logic rxElasticEnable, txClkToggle = 0, txSerialBit = 0;
  logic txHdlcBit = 0, txLegacyBit = 0, txPosIn = 0, txNegIn = 0;
  logic [23:0] txTransparency = 0, sigInsert, bit7Stuff;
  logic txClkUseRx, txFbitFromSerial, txCrcFromSerial, txDatalinkBit;
  logic txLineOutPos, txLineOutNeg, txYellowAlarm;
  logic clkRun = 1;
  logic [31:0] seed = 32'hF10CABCC;
  logic [7:0] rv, d;
  logic [53:0] e;
  int errCount = 0, testsRun = 0, n;

  trc_control_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .busAddr(busAddr), .busWrData(busWrData), .busWrite(busWrite),
    .busRead(busRead), .busRdData(busRdData), .busRdValid(busRdValid),
    .rxByteStrobe(rxByteStrobe), .rxFrameStart(rxFrameStart),
    .rxMultiframeStart(rxMultiframeStart),
    .rxSignalingFrame(rxSignalingFrame), .rxBit2AllZero(rxBit2AllZero),
    .rxFrame12SBit(rxFrame12SBit), .ftBitError(ftBitError),
    .fsBitError(fsBitError), .mfOutOfSync(mfOutOfSync),
    .errCountClear(errCountClear), .replaceCode(replaceCode),
    .rxZbtsiEnable(rxZbtsiEnable), .rxSyncOut(rxSyncOut),
    .rxSyncOe(rxSyncOe), .rxYellowDetected(rxYellowDetected),
    .errCount(errCnt), .rxElasticEnable(rxElasticEnable),
    .txClkToggle(txClkToggle), .txSerialBit(txSerialBit),
    .txHdlcBit(txHdlcBit), .txLegacyBit(txLegacyBit), .txPosIn(txPosIn),
    .txNegIn(txNegIn), .txTransparency(txTransparency),
    .txClkUseRx(txClkUseRx), .txFbitFromSerial(txFbitFromSerial),
    .txCrcFromSerial(txCrcFromSerial), .sigInsert(sigInsert),
    .bit7Stuff(bit7Stuff), .txDatalinkBit(txDatalinkBit),
    .txLineOutPos(txLineOutPos), .txLineOutNeg(txLineOutNeg),
    .txYellowAlarm(txYellowAlarm));

  always #5 ref_clk = ~ref_clk;
  // Keeps the failover detector quiet except when a test stops it
  always @(negedge ref_clk) if (clkRun) txClkToggle <= ~txClkToggle;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [53:0] expTx(logic [7:0] c);
    return {c[5], c[6], {24{c[4]}} & ~txTransparency,
      {24{c[3]}} | txTransparency, c[2] ? txHdlcBit : txLegacyBit,
      c[1] | txPosIn, c[1] | txNegIn, c[0]};
  endfunction

  task automatic close_out();
    $display("Tests run %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    busAddr = a;
    busWrData = v;
    busWrite = 1;
    tick(1);
    busWrite = 0;
    tick(2);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    int i;
    busAddr = a;
    busRead = 1;
    tick(1);
    busRead = 0;
    for (i = 0; i < 4 && busRdValid !== 1'b1; i++) tick(1);
    if (i == 4) begin
      errCount++;
      close_out();
    end else begin
      v = busRdData;
      tick(1);
    end
  endtask

  // Counts sync output cycles after one frame start
  task automatic syncRun(input logic m, input logic s, output int c);
    rxFrameStart = 1;
    rxMultiframeStart = m;
    rxSignalingFrame = s;
    tick(1);
    rxFrameStart = 0;
    rxMultiframeStart = 0;
    c = 0;
    repeat (5) begin
      c += (rxSyncOut === 1'b1);
      tick(1);
    end
    rxSignalingFrame = 0;
  endtask

  initial begin
    tick(4);
    rst_n = 1;
    tick(1);
    check(replaceCode, 8'h7F);
    check(rxSyncOe, 1);
    for (int i = 0; i < 3; i++) begin
      rd(i == 0 ? RX_CTRL_TWO_ADDR : i == 1 ? TX_CTRL_ONE_ADDR : 8'h40, rv);
      check(rv, 8'h00);
    end
    wr(8'h40, 8'hA5);
    rd(8'h40, rv);
    check(rv, UNMAPPED_READ);
    $display("Reset and unmapped test done");

    for (int k = 0; k < 24; k++) begin
      d = rnd();
      txTransparency = rnd();
      {txHdlcBit, txLegacyBit, txPosIn, txNegIn, txSerialBit} = rnd();
      wr(TX_CTRL_ONE_ADDR, d);
      e = expTx(d);
      check({txCrcFromSerial, txFbitFromSerial}, e[53:52]);
      check({sigInsert, bit7Stuff}, e[51:4]);
      check({txDatalinkBit, txLineOutPos}, e[3:2]);
      check(txLineOutNeg, e[1]);
      check(txYellowAlarm, e[0]);
      check(txClkUseRx, 0);
      rd(TX_CTRL_ONE_ADDR, rv);
      check(rv, d);
      d = rnd() & 8'hD7;
      wr(RX_CTRL_TWO_ADDR, d);
      check({rxZbtsiEnable, rxSyncOe}, {d[6], 1'b1});
      if (!d[7]) check(replaceCode, IDLE_CODE);
      rd(RX_CTRL_TWO_ADDR, rv);
      check(rv, d);
    end
    $display("Random register test done");

    wr(RX_CTRL_TWO_ADDR, 8'h80);
    for (int k = 0; k < 2 * MILLIWATT_LEN; k++) begin
      rxByteStrobe = 1;
      tick(1);
      rxByteStrobe = 0;
      tick(1);
      check(replaceCode, MILLIWATT_SEQ[63 - 8 * (k % 8) -: 8]);
    end
    wr(RX_CTRL_TWO_ADDR, 8'h00);
    check(replaceCode, IDLE_CODE);
    $display("Replacement code test done");

    syncRun(0, 1, n);
    check(n, 1);
    wr(RX_CTRL_TWO_ADDR, 8'h20);
    syncRun(0, 1, n);
    check(n, 2);
    syncRun(0, 0, n);
    check(n, 1);
    wr(RX_CTRL_TWO_ADDR, 8'h10);
    syncRun(0, 0, n);
    check(n, 0);
    syncRun(1, 0, n);
    check(n, 1);
    wr(COMMON_CTRL_ONE_ADDR, 8'h04);
    check(rxElasticEnable, 1);
    rd(COMMON_CTRL_ONE_ADDR, rv);
    check(rv, 8'h04);
    wr(RX_CTRL_TWO_ADDR, 8'h18);
    check(rxSyncOe, 0);
    $display("Sync pin test done");

    for (int k = 0; k < 8; k++) begin
      wr(RX_CTRL_TWO_ADDR, {5'h00, k[2], 2'h0});
      {rxBit2AllZero, rxFrame12SBit} = k[1:0];
      tick(2);
      check(rxYellowDetected, k[2] ? k[0] : k[1]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(RX_CTRL_TWO_ADDR, i == 0 ? 8'h00 : i == 1 ? 8'h02 :
        i == 2 ? 8'h01 : 8'h03);
      errCountClear = 1;
      tick(1);
      errCountClear = 0;
      for (int k = 0; k < 6; k++) begin
        ftBitError = k < 3;
        fsBitError = k == 3 || k == 4;
        mfOutOfSync = k == 5;
        tick(1);
      end
      {ftBitError, fsBitError, mfOutOfSync} = 3'h0;
      tick(2);
      check(errCnt, i == 0 ? 3 : i == 1 ? 5 : 1);
    end
    $display("Yellow and counter test done");

    for (int k = 0; k < 2; k++) begin
      wr(TX_CTRL_ONE_ADDR, {k[0], 7'h00});
      clkRun = 0;
      n = 0;
      while (txClkUseRx !== 1'b1 && n < 150) begin
        tick(1);
        n++;
      end
      check(txClkUseRx, k[0]);
      if (k) check(n >= TX_CLK_LOSS_CYCLES && n <= TX_CLK_LOSS_CYCLES + 4,
        1);
      clkRun = 1;
      tick(8);
      check(txClkUseRx, 0);
    end
    $display("Clock failover test done");
    close_out();
  end
endmodule
`default_nettype wire
